// ### hw/rca_alu.sv
// 8-bit two's-complement alu with carry, digit and zero flags
`timescale 1ns/10ps
module rca_alu (
  input wire rca_pkg::rca_op_t op_i,
  input wire logic [7:0] w_i,
  input wire logic [7:0] f_i,
  input wire logic c_in_i,
  output logic [7:0] res_o,
  output rca_pkg::rca_flags_t flg_o
);
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res_o = 8'h00;
    flg_o.c = c_in_i;
    flg_o.dc = 1'b0;
    unique case (op_i)
      rca_pkg::RCA_OP_PASSF: res_o = f_i;
      rca_pkg::RCA_OP_PASSW: res_o = w_i;
      rca_pkg::RCA_OP_ADD: begin
        sum = {1'b0, f_i} + {1'b0, w_i};
        nib = {1'b0, f_i[3:0]} + {1'b0, w_i[3:0]};
        res_o = sum[7:0];
        flg_o.c = sum[8];
        flg_o.dc = nib[4];
      end
      rca_pkg::RCA_OP_SUB: begin
        sum = {1'b0, f_i} + {1'b0, ~w_i} + 9'h001;
        nib = {1'b0, f_i[3:0]} + {1'b0, ~w_i[3:0]} + 5'h01;
        res_o = sum[7:0];
        flg_o.c = sum[8];
        flg_o.dc = nib[4];
      end
      rca_pkg::RCA_OP_AND: res_o = w_i & f_i;
      rca_pkg::RCA_OP_IOR: res_o = w_i | f_i;
      rca_pkg::RCA_OP_XOR: res_o = w_i ^ f_i;
      rca_pkg::RCA_OP_COM: res_o = ~f_i;
      rca_pkg::RCA_OP_INC: res_o = f_i + 8'h01;
      rca_pkg::RCA_OP_DEC: res_o = f_i - 8'h01;
      rca_pkg::RCA_OP_RLF: begin
        res_o = {f_i[6:0], c_in_i};
        flg_o.c = f_i[7];
      end
      rca_pkg::RCA_OP_RRF: begin
        res_o = {c_in_i, f_i[7:1]};
        flg_o.c = f_i[0];
      end
      rca_pkg::RCA_OP_SWAP: res_o = {f_i[3:0], f_i[7:4]};
      rca_pkg::RCA_OP_CLR: res_o = 8'h00;
      default: res_o = 8'h00;
    endcase
    flg_o.z = (res_o == 8'h00);
  end
endmodule

// ### hw/rca_core.sv
// two-stage fetch/execute risc core datapath
// Behaviour
// - separate program and data buses, fetch and data access same cycle
// - 14-bit instruction words, one fetched per instruction cycle
// - fetch of next instruction overlaps execution of current
// - non-branch instructions finish in one instruction cycle
// - 8-bit alu does add, subtract, shifts and logic
// - arithmetic is two's complement
// - two-operand ops use accumulator with file register or literal
// - single-operand ops act on accumulator or file register
// - accumulator is 8-bit and has no data address
// - alu updates carry, digit carry and zero flags in status
// - in subtraction carry flags mean no-borrow
// - special registers including pc are in data space, direct or indirect
// - any operation works on any register by any addressing mode
// - rc mode drives instruction rate clock at quarter oscillator rate
// - master clear low holds core in reset
`timescale 1ns/10ps
module rca_core #(
  parameter int PC_W = rca_pkg::PC_W
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic rc_mode_i,
  input wire logic [13:0] imem_rdata_i,
  input wire logic [7:0] dmem_rdata_i,
  output logic [12:0] imem_addr_o,
  output rca_pkg::rca_dmem_req_t dmem_req_o,
  output logic instruction_rate_out_o,
  output logic [7:0] w_o,
  output logic [7:0] status_o
);
  // one instruction cycle spans four oscillator phases
  localparam logic [1:0] LAST_PHASE = 2'(rca_pkg::CYCLE_CLKS - 1);
  logic [1:0] phase_r;
  logic cyc_en;
  logic [12:0] pc_r;
  logic [13:0] ir_r;
  logic flush_r;
  logic [7:0] w_r;
  logic [7:0] status_r;
  logic [7:0] fsr_r;
  logic [4:0] pclath_r;
  logic [7:0] fval;
  logic [6:0] faddr;
  logic [7:0] alu_res;
  rca_pkg::rca_flags_t alu_flg;
  rca_pkg::rca_op_t op;
  logic [7:0] opf;
  logic use_lit;
  logic dest_f;
  logic upd_z;
  logic upd_cdc;
  logic br_taken;
  logic [12:0] br_target;
  logic skip;
  // skip requests that do not depend on the alu result, and skip-on-zero
  logic skip_pre;
  logic skz;
  logic wr_w;
  logic wr_f;
  logic [7:0] lit;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign cyc_en = (phase_r == LAST_PHASE);

  // quarter-rate clock out only in rc mode
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      instruction_rate_out_o <= 1'b0;
    end else begin
      instruction_rate_out_o <= rc_mode_i & phase_r[1];
    end
  end

  assign lit = ir_r[7:0];
  // indirect through address zero uses fsr
  assign faddr = (ir_r[6:0] == rca_pkg::ADDR_INDF) ? fsr_r[6:0] : ir_r[6:0];

  // special registers read from the core, others from data memory
  always_comb begin
    unique case (faddr)
      rca_pkg::ADDR_PCL: fval = pc_r[7:0];
      rca_pkg::ADDR_STATUS: fval = status_r;
      rca_pkg::ADDR_FSR: fval = fsr_r;
      rca_pkg::ADDR_PCLATH: fval = {3'h0, pclath_r};
      default: fval = dmem_rdata_i;
    endcase
  end

  // instruction decode; byte-oriented, bit-oriented, literal and branch groups
  always_comb begin
    op = rca_pkg::RCA_OP_PASSF;
    use_lit = 1'b0;
    dest_f = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    br_taken = 1'b0;
    br_target = pc_r;
    skip_pre = 1'b0;
    skz = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    opf = fval;
    unique case (ir_r[13:12])
      2'h0: begin
        // byte-oriented ops on f, result to w or f via dest bit
        dest_f = ir_r[7];
        wr_f = ir_r[7];
        wr_w = ~ir_r[7];
        unique case (ir_r[11:8])
          4'h0: begin
            wr_w = 1'b0;
            wr_f = ir_r[7];
            op = rca_pkg::RCA_OP_PASSW;
          end
          4'h1: begin
            op = rca_pkg::RCA_OP_CLR;
            upd_z = 1'b1;
          end
          4'h2: begin
            op = rca_pkg::RCA_OP_SUB;
            upd_z = 1'b1;
            upd_cdc = 1'b1;
          end
          4'h3: begin
            op = rca_pkg::RCA_OP_DEC;
            upd_z = 1'b1;
          end
          4'h4: begin
            op = rca_pkg::RCA_OP_IOR;
            upd_z = 1'b1;
          end
          4'h5: begin
            op = rca_pkg::RCA_OP_AND;
            upd_z = 1'b1;
          end
          4'h6: begin
            op = rca_pkg::RCA_OP_XOR;
            upd_z = 1'b1;
          end
          4'h7: begin
            op = rca_pkg::RCA_OP_ADD;
            upd_z = 1'b1;
            upd_cdc = 1'b1;
          end
          4'h8: begin
            op = rca_pkg::RCA_OP_PASSF;
            upd_z = 1'b1;
          end
          4'h9: begin
            op = rca_pkg::RCA_OP_COM;
            upd_z = 1'b1;
          end
          4'hA: begin
            op = rca_pkg::RCA_OP_INC;
            upd_z = 1'b1;
          end
          4'hB: begin
            op = rca_pkg::RCA_OP_DEC;
            skz = 1'b1;
          end
          4'hC: op = rca_pkg::RCA_OP_RRF;
          4'hD: op = rca_pkg::RCA_OP_RLF;
          4'hE: op = rca_pkg::RCA_OP_SWAP;
          4'hF: begin
            op = rca_pkg::RCA_OP_INC;
            skz = 1'b1;
          end
        endcase
      end
      2'h1: begin
        // bit clear, set and test on any register
        opf = fval;
        op = rca_pkg::RCA_OP_PASSF;
        unique case (ir_r[11:10])
          2'h0: begin
            opf = fval & ~(8'h01 << ir_r[9:7]);
            wr_f = 1'b1;
          end
          2'h1: begin
            opf = fval | (8'h01 << ir_r[9:7]);
            wr_f = 1'b1;
          end
          2'h2: skip_pre = ~fval[ir_r[9:7]];
          2'h3: skip_pre = fval[ir_r[9:7]];
        endcase
        dest_f = wr_f;
      end
      2'h2: begin
        br_taken = 1'b1;
        br_target = {pclath_r[4:3], ir_r[10:0]};
      end
      2'h3: begin
        use_lit = 1'b1;
        wr_w = 1'b1;
        opf = lit;
        unique case (ir_r[11:8])
          4'h8: op = rca_pkg::RCA_OP_IOR;
          4'h9: op = rca_pkg::RCA_OP_AND;
          4'hA: op = rca_pkg::RCA_OP_XOR;
          4'hC, 4'hD: op = rca_pkg::RCA_OP_SUB;
          4'hE, 4'hF: op = rca_pkg::RCA_OP_ADD;
          default: op = rca_pkg::RCA_OP_PASSF;
        endcase
        upd_z = ir_r[11];
        upd_cdc = (ir_r[11:10] == 2'h3);
      end
    endcase
    if (flush_r) begin
      wr_w = 1'b0;
      wr_f = 1'b0;
      upd_z = 1'b0;
      upd_cdc = 1'b0;
      br_taken = 1'b0;
      skip_pre = 1'b0;
      skz = 1'b0;
    end
  end

  // zero test kept outside the decode so the decode never reads its own alu result
  assign skip = skip_pre | (skz & (alu_res == 8'h00));

  rca_alu u_alu (
    .op_i(op),
    .w_i(w_r),
    .f_i(opf),
    .c_in_i(status_r[rca_pkg::ST_C]),
    .res_o(alu_res),
    .flg_o(alu_flg)
  );

  // one 14-bit word per instruction cycle
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pc_r <= rca_pkg::PC_RST;
      ir_r <= rca_pkg::NOP_WORD;
      flush_r <= 1'b1;
    end else if (cyc_en) begin
      ir_r <= imem_rdata_i;
      // discard prefetched word after a redirect
      flush_r <= br_taken | skip | (wr_f & (faddr == rca_pkg::ADDR_PCL));
      if (br_taken) begin
        pc_r <= br_target;
      end else if (wr_f && faddr == rca_pkg::ADDR_PCL) begin
        pc_r <= {pclath_r, alu_res};
      end else begin
        pc_r <= pc_r + 13'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      w_r <= rca_pkg::W_RST;
    end else if (cyc_en && wr_w) begin
      w_r <= alu_res;
    end
  end

  // flag update; explicit writes to status yield to alu flags
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      status_r <= rca_pkg::STATUS_RST;
      fsr_r <= 8'h00;
      pclath_r <= 5'h00;
    end else if (cyc_en) begin
      if (wr_f && faddr == rca_pkg::ADDR_FSR) begin
        fsr_r <= alu_res;
      end
      if (wr_f && faddr == rca_pkg::ADDR_PCLATH) begin
        pclath_r <= alu_res[4:0];
      end
      if (wr_f && faddr == rca_pkg::ADDR_STATUS) begin
        status_r <= alu_res;
      end
      if (upd_z) begin
        status_r[rca_pkg::ST_Z] <= alu_flg.z;
      end
      // subtraction reports borrow as inverted carry
      if (upd_cdc || ((op == rca_pkg::RCA_OP_RLF || op == rca_pkg::RCA_OP_RRF) && !flush_r)) begin
        status_r[rca_pkg::ST_C] <= alu_flg.c;
      end
      if (upd_cdc) begin
        status_r[rca_pkg::ST_DC] <= alu_flg.dc;
      end
    end
  end

  // data port driven in parallel with the fetch address
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      imem_addr_o <= rca_pkg::PC_RST;
      dmem_req_o <= '0;
      w_o <= rca_pkg::W_RST;
      status_o <= rca_pkg::STATUS_RST;
    end else begin
      imem_addr_o <= pc_r;
      dmem_req_o.addr <= faddr;
      dmem_req_o.wdata <= alu_res;
      dmem_req_o.we <= cyc_en & wr_f;
      w_o <= w_r;
      status_o <= status_r;
    end
  end

  a_rate_quarter: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cyc_en |=> !cyc_en [*3] ##1 cyc_en) else $error("cycle enable not every four clocks");
  a_instruction_rate_out_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !rc_mode_i |=> !instruction_rate_out_o) else $error("rate clock out of rc mode");
  a_branch_flush: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cyc_en && br_taken) |=> flush_r && pc_r == $past(br_target)) else $error("branch no flush");
  a_pc_advance: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cyc_en && !br_taken && !(wr_f && faddr == rca_pkg::ADDR_PCL))
      |=> pc_r == $past(pc_r) + 13'h0001) else $error("pc not advanced");
  a_fetch_load: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cyc_en |=> ir_r == $past(imem_rdata_i)) else $error("fetch not loaded");
  a_w_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cyc_en && wr_w) |=> w_r == $past(alu_res)) else $error("w not written");
  a_zero_flag: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cyc_en && upd_z && !(wr_f && faddr == rca_pkg::ADDR_STATUS))
      |=> status_r[rca_pkg::ST_Z] == (($past(alu_res)) == 8'h00)) else $error("zero flag");
  a_sub_borrow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cyc_en && upd_cdc && op == rca_pkg::RCA_OP_SUB && !(wr_f && faddr == rca_pkg::ADDR_STATUS))
      |=> status_r[rca_pkg::ST_C] == ($past(opf) >= $past(w_r))) else $error("borrow");
  a_reset_hold: assert property (@(posedge core_clk_i)
    !reset_n_i |=> pc_r == rca_pkg::PC_RST && phase_r == 2'h0) else $error("reset hold");
  c_branch: cover property (@(posedge core_clk_i) cyc_en && br_taken);
  c_skip: cover property (@(posedge core_clk_i) cyc_en && skip);
  c_sub: cover property (@(posedge core_clk_i) cyc_en && op == rca_pkg::RCA_OP_SUB && upd_cdc);
  c_indirect: cover property (@(posedge core_clk_i) cyc_en && ir_r[6:0] == rca_pkg::ADDR_INDF);
endmodule

// ### hw/rca_pkg.sv
// shared constants and types for the risc core datapath
package rca_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int CYCLE_NS = 200;
  localparam int OSC_MHZ = 20;
  localparam int CLK_MHZ = 25;
  localparam int CYCLE_CLKS = PHASES_PER_CYCLE;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam logic [6:0] ADDR_INDF = 7'h00;
  localparam logic [6:0] ADDR_PCL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_FSR = 7'h04;
  localparam logic [6:0] ADDR_PCLATH = 7'h0A;
  // alu operation codes
  typedef enum logic [3:0] {
    RCA_OP_PASSF = 4'h0, RCA_OP_PASSW = 4'h1, RCA_OP_ADD = 4'h2, RCA_OP_SUB = 4'h3,
    RCA_OP_AND = 4'h4, RCA_OP_IOR = 4'h5, RCA_OP_XOR = 4'h6, RCA_OP_COM = 4'h7,
    RCA_OP_INC = 4'h8, RCA_OP_DEC = 4'h9, RCA_OP_RLF = 4'hA, RCA_OP_RRF = 4'hB,
    RCA_OP_SWAP = 4'hC, RCA_OP_CLR = 4'hD
  } rca_op_t;
  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } rca_flags_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
  } rca_dmem_req_t;
endpackage

// ### tb/risc_core_alu_datapath_bench.sv
// self-checking bench for the risc core datapath, running small programs
`timescale 1ns/10ps
module risc_core_alu_datapath_bench;
  logic core_clk_i;
  logic reset_n_i;
  logic rc_mode_i;
  logic [13:0] imem_rdata_i;
  logic [7:0] dmem_rdata_i;
  logic [12:0] imem_addr_o;
  rca_pkg::rca_dmem_req_t dmem_req_o;
  logic instruction_rate_out_o;
  logic [7:0] w_o;
  logic [7:0] status_o;
  logic [13:0] prog [0:15];
  logic [7:0] dmem [0:127];
  logic [7:0] exp_w [0:15];
  logic [2:0] exp_f [0:15];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_writes = 0;

  rca_core dut_u (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .rc_mode_i(rc_mode_i),
    .imem_rdata_i(imem_rdata_i),
    .dmem_rdata_i(dmem_rdata_i),
    .imem_addr_o(imem_addr_o),
    .dmem_req_o(dmem_req_o),
    .instruction_rate_out_o(instruction_rate_out_o),
    .w_o(w_o),
    .status_o(status_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // memories answer on the falling edge, so the core always samples settled words
  always @(negedge core_clk_i) begin
    imem_rdata_i <= prog[imem_addr_o[3:0]];
    dmem_rdata_i <= dmem[dmem_req_o.addr];
  end

  // capture data writes and cut a hang short; programs need well under 1000 clocks
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (dmem_req_o.we === 1'b1) begin
      dmem[dmem_req_o.addr] <= dmem_req_o.wdata;
      n_writes <= n_writes + 1;
    end
    if (cycles == 4000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
    compares++;
    if (seen !== exp_v) begin
      n_errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  // reset on every program start, often while a previous program still runs
  task automatic start_prog();
    @(negedge core_clk_i);
    reset_n_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(16'(w_o), 16'h0000);
    check(16'(status_o), 16'h0018);
    check(16'(imem_addr_o), 16'h0000);
    check(16'(dmem_req_o.we), 16'h0000);
    check(16'(instruction_rate_out_o), 16'h0000);
    reset_n_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
  endtask

  // one instruction every four clocks, first result after the reset flush
  task automatic run_steps(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check(16'(w_o), 16'(exp_w[i]));
      check(16'(status_o[2:0]), 16'(exp_f[i]));
    end
  endtask

  task automatic alu_literals();
    prog = '{0: 14'h3005, 1: 14'h3EFB, 2: 14'h3C03, 3: 14'h3010, 4: 14'h3C0F,
      5: 14'h390F, 6: 14'h38F0, 7: 14'h3AFF, 8: 14'h3E88, 9: 14'h3E88, default: 14'h0000};
    exp_w = '{0: 8'h05, 1: 8'h00, 2: 8'h03, 3: 8'h10, 4: 8'hFF, 5: 8'h0F, 6: 8'hFF,
      7: 8'h00, 8: 8'h88, 9: 8'h10, default: 8'h00};
    exp_f = '{0: 3'b000, 1: 3'b111, 2: 3'b011, 3: 3'b011, 4: 3'b010, 5: 3'b010,
      6: 3'b010, 7: 3'b110, 8: 3'b000, 9: 3'b011, default: 3'b000};
    start_prog();
    run_steps(10);
  endtask

  task automatic file_ops();
    int base;
    prog = '{0: 14'h3021, 1: 14'h00A0, 2: 14'h0720, 3: 14'h02A0, 4: 14'h0A20,
      5: 14'h3009, 6: 14'h0082, 7: 14'h30EE, 8: 14'h30EE, 9: 14'h305A, default: 14'h0000};
    exp_w = '{0: 8'h21, 1: 8'h21, 2: 8'h42, 3: 8'h42, 4: 8'hE0, 5: 8'h09, 6: 8'h09,
      7: 8'h09, 8: 8'h5A, default: 8'h00};
    exp_f = '{default: 3'b000};
    start_prog();
    base = n_writes;
    run_steps(9);
    check(16'(dmem[7'h20]), 16'h00DF);
    // a held write strobe would count more than three writes here
    check(16'(n_writes - base), 16'h0003);
  endtask

  task automatic branch_flush();
    prog = '{0: 14'h3001, 1: 14'h2804, 2: 14'h30EE, 3: 14'h30EE, 4: 14'h3003,
      5: 14'h3004, default: 14'h0000};
    exp_w = '{0: 8'h01, 1: 8'h01, 2: 8'h01, 3: 8'h03, 4: 8'h04, default: 8'h00};
    exp_f = '{default: 3'b000};
    start_prog();
    run_steps(5);
  endtask

  // indirect access through the pointer register
  task automatic indirect_ops();
    prog = '{0: 14'h3020, 1: 14'h0084, 2: 14'h3055, 3: 14'h0080, 4: 14'h0100,
      5: 14'h0800, default: 14'h0000};
    exp_w = '{0: 8'h20, 1: 8'h20, 2: 8'h55, 3: 8'h55, 4: 8'h00, 5: 8'h55, default: 8'h00};
    exp_f = '{4: 3'b100, default: 3'b000};
    start_prog();
    run_steps(6);
    check(16'(dmem[7'h20]), 16'h0055);
  endtask

  task automatic rate_out();
    logic [15:0] seen;
    logic [7:0] quiet;
    @(negedge core_clk_i);
    rc_mode_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    for (int i = 0; i < 16; i++) begin
      seen[i] = instruction_rate_out_o;
      @(negedge core_clk_i);
    end
    check(16'($countones(seen)), 16'h0008);
    check(16'(seen[15:4]), 16'(seen[11:0]));
    check(16'(seen[1:0] ^ seen[3:2]), 16'h0003);
    rc_mode_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      quiet[i] = instruction_rate_out_o;
      @(negedge core_clk_i);
    end
    check(16'(quiet), 16'h0000);
  endtask

  task automatic results();
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    reset_n_i = 1'b0;
    rc_mode_i = 1'b0;
    imem_rdata_i = 14'h0000;
    dmem_rdata_i = 8'h00;
    dmem = '{default: 8'h00};
    prog = '{default: 14'h0000};
    alu_literals();
    file_ops();
    branch_flush();
    indirect_ops();
    rate_out();
    results();
  end
endmodule
